// ---- core/slep_pkg.sv ----
/*
 * Shared constants and carrier types for the strap latch and event pin block.
 * Assumes a single 25 MHz core clock and an active-low asynchronous reset.
 */
package slep_pkg;

    localparam int SLEP_NUM_GPIO   = 10;
    localparam int SLEP_NUM_FUNC   = 5;
    localparam int SLEP_SEL_W      = 4;
    localparam int SLEP_ADDR_W     = 4;
    localparam int SLEP_NUM_LED    = 5;
    localparam int SLEP_STA_W      = 5;

    // Function codes carried in a pin's routing field; 0 keeps the pin idle.
    localparam logic [3:0] SLEP_FN_NONE    = 4'h0;
    localparam logic [3:0] SLEP_FN_WAKE    = 4'h1;
    localparam logic [3:0] SLEP_FN_SOF_RX  = 4'h2;
    localparam logic [3:0] SLEP_FN_SOF_TX  = 4'h3;
    localparam logic [3:0] SLEP_FN_TIME_A  = 4'h4;
    localparam logic [3:0] SLEP_FN_TIME_B  = 4'h5;

    // Register offsets.
    localparam logic [3:0] SLEP_OFS_OUT_CTRL   = 4'h0;
    localparam logic [3:0] SLEP_OFS_PAD_DRIVE  = 4'h1;
    localparam logic [3:0] SLEP_OFS_TS_CONFIG  = 4'h2;
    localparam logic [3:0] SLEP_OFS_STRAP_STAT = 4'h3;
    localparam logic [3:0] SLEP_OFS_ROUTE_LO   = 4'h4;
    localparam logic [3:0] SLEP_OFS_ROUTE_HI   = 4'h5;

    // Field positions.
    localparam int SLEP_BIT_WAKE_POL   = 0;
    localparam int SLEP_BIT_TPOL_A     = 0;
    localparam int SLEP_BIT_TPOL_B     = 1;
    localparam int SLEP_BIT_STRAP_JACK = 0;
    localparam int SLEP_LSB_STRAP_STA  = 1;
    localparam int SLEP_LSB_STRAP_LED  = 6;

    // Reset values.
    localparam logic [31:0] SLEP_RST_OUT_CTRL  = 32'h0000_0000;
    localparam logic [31:0] SLEP_RST_PAD_DRIVE = 32'h0000_0000;
    localparam logic [31:0] SLEP_RST_TS_CONFIG = 32'h0000_0000;
    localparam logic [31:0] SLEP_RST_ROUTE     = 32'h0000_0000;

    typedef struct packed {
        logic [SLEP_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
        logic                   wr;
        logic                   rd;
    } slep_bus_s;

    typedef struct packed {
        logic                    integrated_jack;
        logic [SLEP_STA_W-1:0]   station_address;
        logic [SLEP_NUM_LED-1:0] indicator_polarity;
    } slep_strap_s;

    typedef struct packed {
        logic wake;
        logic sof_rx;
        logic sof_tx;
        logic time_a;
        logic time_b;
    } slep_event_s;

endpackage

// ---- core/slep_strap_latch.sv ----
/*
 * Strap capture: takes the strap pins on the first clock after reset release.
 * Assumes the board holds the strap levels stable across the release of rst_b.
 */
`timescale 1ns/100ps
module slep_strap_latch
    import slep_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Strap pins
    input  wire slep_strap_s strap_pins,
    // Latched values
    output slep_strap_s      strap_q,
    output logic             strap_done
);

    logic done_reg;
    slep_strap_s strap_reg;
    wire  logic  take = ~done_reg;

    // A constant at reset; pins are sampled only once the reset has gone.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_reg  <= 1'b0;
            strap_reg <= '0;
        end
        else if (take)
        begin
            done_reg  <= 1'b1;
            strap_reg <= strap_pins;
        end
    end

    assign strap_q    = strap_reg;
    assign strap_done = done_reg;

    chk_strap_frozen: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(done_reg) |-> $stable(strap_reg))
        else $error("strap value changed after capture");

    chk_strap_taken: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(done_reg) |-> strap_reg == $past(strap_pins))
        else $error("strap value not taken from pins");

endmodule // slep_strap_latch

// ---- core/slep_event_pins.sv ----
/*
 * Event pin multiplexer with strap capture and a small register port.
 * Assumes event inputs are synchronous one-cycle or level signals on mclk.
 */
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
// How it works
// - Wake output asserts whenever the wake detector reports a wake event.
// - Wake output active level follows the wake polarity bit in output control.
// - Each pin drives push-pull or open-drain per its pad drive bit.
// - Every event function can be routed to any pin through routing registers.
// - Frame-start pulses follow receive and transmit frame starts, always active high.
// - Time event outputs A and B assert on their own counter events.
// - Time events A and B each have their own polarity bit.
// - Integrated-jack strap chooses normal or alternate pad drive defaults.
// - Five station address straps are latched, pulled-up reads as one.
// - LED polarity default: strap zero active high, strap one active low.
// - All straps are taken at release of the reset pin.
module slep_event_pins
    import slep_pkg::*;
#(
    parameter int NUM_GPIO = SLEP_NUM_GPIO
)
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    // Register port
    input  wire logic [SLEP_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    // Event sources
    input  wire logic                    wake_on_lan_event,
    input  wire logic                    sof_rx_pulse,
    input  wire logic                    sof_tx_pulse,
    input  wire logic                    local_time_counter_event_a,
    input  wire logic                    local_time_counter_event_b,
    // Strap pins
    input  wire slep_strap_s             strap_pins,
    // Strap results
    output logic                         integrated_jack_strap,
    output logic [SLEP_STA_W-1:0]        station_address_strap,
    output logic [SLEP_NUM_LED-1:0]      indicator_polarity,
    output logic                         strap_valid,
    // General-purpose pins
    output logic [NUM_GPIO-1:0]          gpio_out,
    output logic [NUM_GPIO-1:0]          gpio_oe_b,
    // Dedicated wake pin view
    output logic                         wake_event_out_n
);

    logic [31:0]                out_ctrl_reg;
    logic [31:0]                pad_drive_reg;
    logic [31:0]                ts_config_reg;
    logic [31:0]                route_lo_reg;
    logic [31:0]                route_hi_reg;
    logic [31:0]                rdata_reg;
    logic [NUM_GPIO-1:0]        gpio_out_reg;
    logic [NUM_GPIO-1:0]        gpio_oe_reg;
    logic                       wake_n_reg;
    logic [NUM_GPIO-1:0]        gpio_out_next;
    logic [NUM_GPIO-1:0]        gpio_oe_next;
    logic                       strap_seen_reg;
    slep_strap_s                strap_q;
    logic                       strap_done;
    slep_event_s                ev_active;
    logic [SLEP_NUM_FUNC:0]     fn_vec;

    slep_strap_latch u_strap
    (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .strap_pins (strap_pins),
        .strap_q    (strap_q),
        .strap_done (strap_done)
    );

    assign integrated_jack_strap = strap_q.integrated_jack;
    assign station_address_strap = strap_q.station_address;
    // A low strap means the LED pulls down to ground, so it is lit when driven high.
    assign indicator_polarity    = ~strap_q.indicator_polarity;
    assign strap_valid           = strap_done;

    function automatic logic [SLEP_SEL_W-1:0] route_sel(input int pin,
                                                      input logic [31:0] lo,
                                                      input logic [31:0] hi);
        logic [63:0] both;
        both = {hi, lo};
        return both[pin*SLEP_SEL_W +: SLEP_SEL_W];
    endfunction

    // Active level inverted here, before routing, so every pin sees the same level.
    assign ev_active.wake   = wake_on_lan_event ^ out_ctrl_reg[SLEP_BIT_WAKE_POL];
    assign ev_active.sof_rx = sof_rx_pulse;
    assign ev_active.sof_tx = sof_tx_pulse;
    assign ev_active.time_a = local_time_counter_event_a ^ ts_config_reg[SLEP_BIT_TPOL_A];
    assign ev_active.time_b = local_time_counter_event_b ^ ts_config_reg[SLEP_BIT_TPOL_B];

    // Index 0 is the idle code; an idle pin sits undriven.
    assign fn_vec = {ev_active.time_b, ev_active.time_a, ev_active.sof_tx,
                     ev_active.sof_rx, ev_active.wake, 1'b0};

    always_comb
    begin
        gpio_out_next = '0;
        gpio_oe_next  = '1;
        for (int p = 0; p < NUM_GPIO; p++)
        begin
            logic [SLEP_SEL_W-1:0] sel;
            logic                  lvl;
            sel = route_sel(p, route_lo_reg, route_hi_reg);
            lvl = (sel <= SLEP_FN_TIME_B) ? fn_vec[sel[2:0]] : 1'b0;
            if (sel != SLEP_FN_NONE && sel <= SLEP_FN_TIME_B)
            begin
                if (pad_drive_reg[p])
                begin
                    // Open-drain: drive low only, release for high.
                    gpio_out_next[p] = 1'b0;
                    gpio_oe_next[p]  = lvl;
                end
                else
                begin
                    gpio_out_next[p] = lvl;
                    gpio_oe_next[p]  = 1'b0;
                end
            end
        end
    end

    // Register writes; alternate defaults follow the jack strap once it is taken.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_ctrl_reg   <= SLEP_RST_OUT_CTRL;
            pad_drive_reg  <= SLEP_RST_PAD_DRIVE;
            ts_config_reg  <= SLEP_RST_TS_CONFIG;
            route_lo_reg   <= SLEP_RST_ROUTE;
            route_hi_reg   <= SLEP_RST_ROUTE;
            strap_seen_reg <= 1'b0;
        end
        else
        begin
            if (strap_done && !strap_seen_reg)
            begin
                strap_seen_reg <= 1'b1;
                if (strap_q.integrated_jack)
                    pad_drive_reg <= ~SLEP_RST_PAD_DRIVE;
            end
            if (reg_wr)
            begin
                case (reg_addr)
                    SLEP_OFS_OUT_CTRL:  out_ctrl_reg  <= reg_wdata;
                    SLEP_OFS_PAD_DRIVE: pad_drive_reg <= reg_wdata;
                    SLEP_OFS_TS_CONFIG: ts_config_reg <= reg_wdata;
                    SLEP_OFS_ROUTE_LO:  route_lo_reg  <= reg_wdata;
                    SLEP_OFS_ROUTE_HI:  route_hi_reg  <= reg_wdata;
                    default:            ;
                endcase
            end
        end
    end

    wire logic [31:0] strap_word = {20'h0_0000, strap_q.indicator_polarity,
                                    strap_q.station_address, strap_q.integrated_jack, strap_done};

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_reg <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                SLEP_OFS_OUT_CTRL:   rdata_reg <= out_ctrl_reg;
                SLEP_OFS_PAD_DRIVE:  rdata_reg <= pad_drive_reg;
                SLEP_OFS_TS_CONFIG:  rdata_reg <= ts_config_reg;
                SLEP_OFS_STRAP_STAT: rdata_reg <= strap_word;
                SLEP_OFS_ROUTE_LO:   rdata_reg <= route_lo_reg;
                SLEP_OFS_ROUTE_HI:   rdata_reg <= route_hi_reg;
                default:             rdata_reg <= 32'h0000_0000;
            endcase
        end
        else
            rdata_reg <= 32'h0000_0000;
    end

    // Pins and the wake view are registered, one cycle behind their source.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gpio_out_reg <= '0;
            gpio_oe_reg  <= '1;
            wake_n_reg   <= 1'b1;
        end
        else
        begin
            gpio_out_reg <= gpio_out_next;
            gpio_oe_reg  <= gpio_oe_next;
            wake_n_reg   <= ~ev_active.wake;
        end
    end

    assign reg_rdata        = rdata_reg;
    assign gpio_out         = gpio_out_reg;
    assign gpio_oe_b        = gpio_oe_reg;
    assign wake_event_out_n = wake_n_reg;

    // The first edge after release still shows the reset level of the flop, so it is skipped.
    chk_wake_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(rst_b) |-> wake_event_out_n == ~($past(wake_on_lan_event) ^ $past(out_ctrl_reg[SLEP_BIT_WAKE_POL])))
        else $error("wake pin does not follow wake event");

    chk_wake_polarity: assert property (@(posedge mclk) disable iff (!rst_b)
        ($past(out_ctrl_reg[SLEP_BIT_WAKE_POL]) && $past(wake_on_lan_event)) |-> wake_event_out_n)
        else $error("wake polarity bit not honoured");

    chk_pin_push_pull: assert property (@(posedge mclk) disable iff (!rst_b)
        (route_sel(0, route_lo_reg, route_hi_reg) == SLEP_FN_SOF_RX && !pad_drive_reg[0]
         && $stable(route_lo_reg) && $stable(pad_drive_reg))
        |=> (gpio_oe_b[0] == 1'b0 && gpio_out[0] == $past(sof_rx_pulse)))
        else $error("push-pull pin not driving frame start");

    chk_pin_open_drain: assert property (@(posedge mclk) disable iff (!rst_b)
        (route_sel(0, route_lo_reg, route_hi_reg) != SLEP_FN_NONE && pad_drive_reg[0])
        |=> gpio_out[0] == 1'b0)
        else $error("open-drain pin drove high");

    chk_route_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        (route_sel(1, route_lo_reg, route_hi_reg) == SLEP_FN_NONE) |=> gpio_oe_b[1])
        else $error("idle pin is driven");

    chk_sof_tx_high: assert property (@(posedge mclk) disable iff (!rst_b)
        (route_sel(0, route_lo_reg, route_hi_reg) == SLEP_FN_SOF_TX && !pad_drive_reg[0] && sof_tx_pulse)
        |=> gpio_out[0])
        else $error("transmit frame start not active high");

    chk_time_b_pol: assert property (@(posedge mclk) disable iff (!rst_b)
        (route_sel(2, route_lo_reg, route_hi_reg) == SLEP_FN_TIME_B && !pad_drive_reg[2])
        |=> gpio_out[2] == ($past(local_time_counter_event_b) ^ $past(ts_config_reg[SLEP_BIT_TPOL_B])))
        else $error("time event b level wrong");

    chk_led_default: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(strap_done) |-> indicator_polarity == ~$past(strap_pins.indicator_polarity))
        else $error("indicator polarity default wrong");

endmodule // slep_event_pins

// ---- dv/slep_board_model.sv ----
/*
 * Board-side model: strap resistors on the shared strap pins and pull-ups on the event pins.
 * Assumes the block drives gpio_out and gpio_oe_b and raises strap_valid once straps are taken.
 */
`timescale 1ns/100ps
module slep_board_model
    import slep_pkg::*;
(
    // Clock
    input  wire logic                     mclk,
    // Board strap setting and strap status
    input  wire slep_strap_s              strap_value,
    input  wire logic                     strap_valid,
    // Pin drive from the block
    input  wire logic [SLEP_NUM_GPIO-1:0] gpio_out,
    input  wire logic [SLEP_NUM_GPIO-1:0] gpio_oe_b,
    // Strap pins and resolved pin levels
    output slep_strap_s                   strap_pins,
    output logic [SLEP_NUM_GPIO-1:0]      pin_level
);
    slep_strap_s wig_reg;

    // Straps are steady up to the taking edge; after it every strap pin toggles every cycle.
    always_ff @(posedge mclk)
        wig_reg <= strap_valid ? slep_strap_s'(~wig_reg) : slep_strap_s'(~strap_value);
    assign strap_pins = strap_valid ? wig_reg : strap_value;

    // Every pin has a pull-up, so a released pin reads high.
    assign pin_level = gpio_oe_b | gpio_out;
endmodule // slep_board_model

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench for the event pin multiplexer and strap capture.
 * Assumes the board model on the strap and event pins and a 25 MHz mclk.
 */
`timescale 1ns/100ps
module tb_top
    import slep_pkg::*;
;
    logic                   mclk, rst_b, reg_wr, reg_rd, jack_q, valid_q, wake_n, wpol, pola, polb;
    logic [SLEP_ADDR_W-1:0] reg_addr;
    logic [31:0]            reg_wdata, reg_rdata;
    slep_strap_s            strap_value, strap_pins;
    slep_event_s            ev;
    logic [4:0]             sta_q, ledp_q;
    logic [9:0]             gpio_out, gpio_oe_b, pin_level, pad;
    logic [3:0]             route [SLEP_NUM_GPIO];
    int                     n_errors, comparisons;

    slep_event_pins u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_on_lan_event(ev.wake),
        .sof_rx_pulse(ev.sof_rx), .sof_tx_pulse(ev.sof_tx), .local_time_counter_event_a(ev.time_a),
        .local_time_counter_event_b(ev.time_b), .strap_pins(strap_pins), .integrated_jack_strap(jack_q),
        .station_address_strap(sta_q), .indicator_polarity(ledp_q), .strap_valid(valid_q),
        .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b), .wake_event_out_n(wake_n));
    slep_board_model u_board (.mclk(mclk), .strap_value(strap_value), .strap_valid(valid_q),
        .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b), .strap_pins(strap_pins), .pin_level(pin_level));

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Expected {out, oe_b} of one pin; polarity is applied before routing, so drive type never alters it.
    function automatic logic [1:0] pin_exp(input logic [3:0] c, input logic od, input slep_event_s e);
        logic l;
        case (c)
            SLEP_FN_WAKE:   l = e.wake ^ wpol;
            SLEP_FN_SOF_RX: l = e.sof_rx;
            SLEP_FN_SOF_TX: l = e.sof_tx;
            SLEP_FN_TIME_A: l = e.time_a ^ pola;
            SLEP_FN_TIME_B: l = e.time_b ^ polb;
            default:        return 2'b01;
        endcase
        return od ? {1'b0, l} : {l, 1'b0};
    endfunction

    task automatic reset_dut(input slep_strap_s s);
        logic [31:0] d;
        strap_value <= s;
        ev <= '0;
        rst_b <= 1'b0;
        repeat (12) @(posedge mclk);
        #1 chk("strap_valid in reset", valid_q, 0);
        @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("jack strap", jack_q, s.integrated_jack);
        chk("station address", sta_q, s.station_address);
        chk("led polarity", ledp_q, 5'(~s.indicator_polarity));
        chk("strap_valid", valid_q, 1);
        rd(SLEP_OFS_STRAP_STAT, d);
        chk("strap status", d, {20'h0, s.indicator_polarity, s.station_address, s.integrated_jack, 1'b1});
    endtask

    task automatic configure(input bit wpad);
        logic [31:0] lo, hi, d;
        lo = '0;
        for (int p = 0; p < 8; p++)
            lo[4*p +: 4] = route[p];
        hi = {24'h0, route[9], route[8]};
        wr(SLEP_OFS_OUT_CTRL, {31'h0, wpol});
        wr(SLEP_OFS_TS_CONFIG, {30'h0, polb, pola});
        if (wpad)
            wr(SLEP_OFS_PAD_DRIVE, {22'h0, pad});
        wr(SLEP_OFS_ROUTE_LO, lo);
        wr(SLEP_OFS_ROUTE_HI, hi);
        rd(SLEP_OFS_ROUTE_LO, d);
        chk("route_lo", d, lo);
        rd(SLEP_OFS_TS_CONFIG, d);
        chk("ts_config", d, {30'h0, polb, pola});
    endtask

    task automatic run_events(input int n);
        slep_event_s prev;
        logic [1:0]  x;
        prev = ev;
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            ev <= slep_event_s'(5'($urandom));
            #1 chk("wake pin", wake_n, 1'(~(prev.wake ^ wpol)));
            for (int p = 0; p < SLEP_NUM_GPIO; p++)
            begin
                x = pin_exp(route[p], pad[p], prev);
                chk("pin drive", {gpio_out[p], gpio_oe_b[p]}, x);
                chk("pin level", pin_level[p], x[1] | x[0]);
            end
            prev = ev;
        end
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] d;
        rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
        ev = '0; strap_value = '0; n_errors = 0; comparisons = 0;
        wpol = 1'b0; pola = 1'b0; polb = 1'b0; pad = '0;
        void'($urandom(77));
        reset_dut(slep_strap_s'({1'b0, 5'h1f, 5'h0a}));
        rd(SLEP_OFS_PAD_DRIVE, d);
        chk("pad drive default", d, 0);
        wr(4'hf, $urandom);
        rd(4'hf, d);
        chk("unmapped read", d, 0);
        rd(SLEP_OFS_ROUTE_LO, d);
        chk("route_lo default", d, 0);
        for (int r = 0; r < 4; r++)
        begin
            for (int p = 0; p < SLEP_NUM_GPIO; p++)
                route[p] = (r == 0) ? 4'((p % 5) + 1) : 4'($urandom_range(0, 7));
            pad = (r == 0) ? 10'h3e0 : 10'($urandom);
            {wpol, pola, polb} = 3'($urandom);
            configure(1'b1);
            run_events(40);
        end
        reset_dut(slep_strap_s'({1'b1, 10'($urandom)}));
        pad = 10'h3ff;
        {wpol, pola, polb} = 3'($urandom);
        configure(1'b0);
        run_events(40);
        tally_and_finish();
    end
endmodule // tb_top
